/* File: src/dph_pkg.sv */
/*
  Shared constants for the two-sided handshake port adapter: register
  select codes, control bit positions, reset values, control line modes.
  Assumes every file that uses these constants imports this package.
*/
// What this block does
// - Active side A strobe edge sets control bit 7 regardless of enable.
// - Control bit 1 picks strobe edge: 0 falling, 1 rising.
// - Bit 5 low: aux line is input; edge per bit 4 sets bit 6.
// - Mode 101 on side A: aux line pulses on each port A data read.
// - Mode 100 on side A: aux line driven low by port A data read.
// - Mode 100 on side A: strobe edge drives aux line high again.
// - Bits 5 and 4 high: aux line statically follows bit 3.
// - Side B strobe edge sets side B bit 7 like side A.
// - Side B aux inputs match A; pulse triggered by port B latch write.
// - Side B handshake paces processor-to-peripheral transfers.
// - Interrupt requests are active-low open-drain, wire-OR capable.
// - Side A bit 7 drives request only while bit 0 set.
// - Side A bit 6 drives request only while bit 3 set.
// - Port A data read clears side A bits 6 and 7.
// - Side B request gated like side A by bits 0 and 3.
// - Port B data read clears side B bits 6 and 7.
// - Direction bit 1 makes pin output, 0 makes it input.
// - Port A reads return pin levels, outputs included.
// - Port B reads return latch value for output lines.
// - Port B input lines undriven; pin levels returned on read.
// - Control bit 2: 0 selects direction register, 1 latch and port.
// - Reset clears every register but the aux level, which resets high, leaving all pins as inputs.
package dph_pkg;
  localparam logic [1:0] RS_A_DATA = 2'h0;
  localparam logic [1:0] RS_A_CTRL = 2'h1;
  localparam logic [1:0] RS_B_DATA = 2'h2;
  localparam logic [1:0] RS_B_CTRL = 2'h3;

  localparam int CTL_STROBE_EN   = 0;
  localparam int CTL_STROBE_EDGE = 1;
  localparam int CTL_DATA_SEL    = 2;
  localparam int CTL_AUX_B3      = 3;
  localparam int CTL_AUX_B4      = 4;
  localparam int CTL_AUX_OUTPUT  = 5;
  localparam int CTL_AUX_FLAG    = 6;
  localparam int CTL_STROBE_FLAG = 7;

  localparam logic [5:0] CTRL_RST  = 6'h00;
  localparam logic [7:0] DIR_RST   = 8'h00;
  localparam logic [7:0] LATCH_RST = 8'h00;
  localparam logic [7:0] DATA_RST  = 8'h00;

  localparam logic [1:0] AUX_MODE_HANDSHAKE = 2'h0;
  localparam logic [1:0] AUX_MODE_PULSE     = 2'h1;
endpackage

/* File: src/dph_side_if.sv */
/*
  Bundle between the register core and one side's control line logic.
  Assumes one instance per side, driven from the top module.
*/
`timescale 1ns/10ps
interface dph_side_if;
  logic [5:0] ctrl;
  logic       trigger;
  logic       clear;
  logic       strobe_flag;
  logic       aux_flag;
  logic       irq;
  logic       aux_out;
  logic       aux_oe;

  modport core
  (
    output ctrl,
    output trigger,
    output clear,
    input  strobe_flag,
    input  aux_flag,
    input  irq,
    input  aux_out,
    input  aux_oe
  );
  modport line
  (
    input  ctrl,
    input  trigger,
    input  clear,
    output strobe_flag,
    output aux_flag,
    output irq,
    output aux_out,
    output aux_oe
  );
endinterface

/* File: src/dph_line_logic.sv */
/*
  Strobe and aux control line logic of one side: edge detection, flags,
  aux output modes, interrupt request.
  Assumes strobe and aux inputs synchronous to mclk; trigger and clear
  are one-cycle pulses from the register core.
*/
`timescale 1ns/10ps
module dph_line_logic
  import dph_pkg::*;
(
  input  wire logic mclk,
  input  wire logic srst,
  input  wire logic ce,
  input  wire logic strobe_in,
  input  wire logic aux_in,
  dph_side_if.line  sif
);
  logic       strobe_prev_q;
  logic       aux_prev_q;
  logic       seen_q;
  logic       strobe_flag_q;
  logic       aux_flag_q;
  logic       aux_level_q;
  logic       aux_level_d;
  logic       aux_is_out;
  logic       strobe_edge;
  logic       aux_edge;
  logic [1:0] out_mode;

  // no edge before the first sample after reset, avoids a false edge
  assign strobe_edge = seen_q & (sif.ctrl[CTL_STROBE_EDGE] ? (~strobe_prev_q & strobe_in)
                                                           : (strobe_prev_q & ~strobe_in));
  assign aux_is_out  = sif.ctrl[CTL_AUX_OUTPUT];
  assign aux_edge    = seen_q & ~aux_is_out & (sif.ctrl[CTL_AUX_B4] ? (~aux_prev_q & aux_in)
                                                                    : (aux_prev_q & ~aux_in));
  assign out_mode    = {sif.ctrl[CTL_AUX_B4], sif.ctrl[CTL_AUX_B3]};

  always_comb
  begin
    aux_level_d = 1'b1;
    if (aux_is_out && sif.ctrl[CTL_AUX_B4])
      aux_level_d = sif.ctrl[CTL_AUX_B3];
    else if (aux_is_out && out_mode == AUX_MODE_PULSE)
      aux_level_d = ~sif.trigger;
    else if (aux_is_out && out_mode == AUX_MODE_HANDSHAKE)
    begin
      if (strobe_edge)
        aux_level_d = 1'b1;
      else if (sif.trigger)
        aux_level_d = 1'b0;
      else
        aux_level_d = aux_level_q;
    end
  end

  always_ff @(posedge mclk)
  begin
    if (srst)
    begin
      strobe_prev_q <= 1'b0;
      aux_prev_q    <= 1'b0;
      seen_q        <= 1'b0;
      strobe_flag_q <= 1'b0;
      aux_flag_q    <= 1'b0;
      aux_level_q   <= 1'b1;
    end
    else if (ce)
    begin
      strobe_prev_q <= strobe_in;
      aux_prev_q    <= aux_in;
      seen_q        <= 1'b1;
      // a set in the clearing cycle wins
      strobe_flag_q <= strobe_edge | (strobe_flag_q & ~sif.clear);
      aux_flag_q    <= aux_edge | (aux_flag_q & ~sif.clear & ~aux_is_out);
      aux_level_q   <= aux_level_d;
    end
  end

  assign sif.strobe_flag = strobe_flag_q;
  assign sif.aux_flag    = aux_flag_q;
  assign sif.irq         = (strobe_flag_q & sif.ctrl[CTL_STROBE_EN])
                         | (aux_flag_q & sif.ctrl[CTL_AUX_B3]);
  assign sif.aux_out     = aux_level_q;
  assign sif.aux_oe      = aux_is_out;
endmodule

/* File: src/dph_port_io.sv */
/*
  One 8-bit peripheral port: pin drive and read-back selection.
  Assumes pins sampled synchronously; wire level resolved outside.
*/
`timescale 1ns/10ps
module dph_port_io
#(
  parameter bit READ_LATCH = 1'b0
)
(
  input  wire logic [7:0] dir,
  input  wire logic [7:0] latch,
  input  wire logic [7:0] pins_in,
  output logic      [7:0] pins_out,
  output logic      [7:0] pins_oe,
  output logic      [7:0] rd_val
);
  genvar i;
  generate
    for (i = 0; i < 8; i++)
    begin : g_bit
      assign pins_out[i] = latch[i];
      assign pins_oe[i]  = dir[i];
      // latch read-back keeps a loaded output from reading wrong
      assign rd_val[i]   = (READ_LATCH && dir[i]) ? latch[i] : pins_in[i];
    end
  endgenerate
endmodule

/* File: src/dph_top.sv */
/*
  Two-sided handshake port adapter: processor register access,
  direction and output latches, two control line blocks, interrupt pins.
  Assumes a synchronous processor access: each mclk cycle with ce high
  and the chip selected is one access; read data appears one cycle later.
*/
`timescale 1ns/10ps
module dph_top
  import dph_pkg::*;
(
  input  wire logic       mclk,
  input  wire logic       srst,
  input  wire logic       ce,
  input  wire logic       cs0,
  input  wire logic       cs1,
  input  wire logic       cs2_n,
  input  wire logic       read_not_write,
  input  wire logic       reg_select_lo,
  input  wire logic       reg_select_hi,
  input  wire logic [7:0] data_in,
  output logic      [7:0] data_out,
  output logic            data_oe,
  input  wire logic [7:0] side_a_pins_in,
  output logic      [7:0] side_a_pins_out,
  output logic      [7:0] side_a_pins_oe,
  input  wire logic [7:0] side_b_pins_in,
  output logic      [7:0] side_b_pins_out,
  output logic      [7:0] side_b_pins_oe,
  input  wire logic       side_a_strobe_in,
  input  wire logic       side_a_aux_line_in,
  output logic            side_a_aux_line_out,
  output logic            side_a_aux_line_oe,
  input  wire logic       side_b_strobe_in,
  input  wire logic       side_b_aux_line_in,
  output logic            side_b_aux_line_out,
  output logic            side_b_aux_line_oe,
  output logic            side_a_int_req_n_out,
  output logic            side_a_int_req_n_oe,
  output logic            side_b_int_req_n_out,
  output logic            side_b_int_req_n_oe
);
  import dph_pkg::*;

  dph_side_if side_a_if ();
  dph_side_if side_b_if ();

  logic [5:0] side_a_control_q;
  logic [5:0] side_b_control_q;
  logic [7:0] side_a_direction_q;
  logic [7:0] side_b_direction_q;
  logic [7:0] side_a_out_latch_q;
  logic [7:0] side_b_out_latch_q;
  logic [7:0] data_out_q;
  logic       data_oe_q;
  logic [7:0] a_rd_val;
  logic [7:0] b_rd_val;
  logic [7:0] rd_mux;
  logic [7:0] a_ctrl_rd;
  logic [7:0] b_ctrl_rd;
  logic [1:0] rsel;
  logic       acc;
  logic       rd;
  logic       wr;
  logic       a_port_sel;
  logic       b_port_sel;
  logic       a_dir_sel;
  logic       b_dir_sel;
  logic       a_ctrl_sel;
  logic       b_ctrl_sel;

  assign rsel       = {reg_select_hi, reg_select_lo};
  assign acc        = ce & cs0 & cs1 & ~cs2_n;
  assign rd         = acc & read_not_write;
  assign wr         = acc & ~read_not_write;
  assign a_port_sel = (rsel == RS_A_DATA) & side_a_control_q[CTL_DATA_SEL];
  assign a_dir_sel  = (rsel == RS_A_DATA) & ~side_a_control_q[CTL_DATA_SEL];
  assign b_port_sel = (rsel == RS_B_DATA) & side_b_control_q[CTL_DATA_SEL];
  assign b_dir_sel  = (rsel == RS_B_DATA) & ~side_b_control_q[CTL_DATA_SEL];
  assign a_ctrl_sel = (rsel == RS_A_CTRL);
  assign b_ctrl_sel = (rsel == RS_B_CTRL);

  assign a_ctrl_rd  = {side_a_if.strobe_flag, side_a_if.aux_flag, side_a_control_q};
  assign b_ctrl_rd  = {side_b_if.strobe_flag, side_b_if.aux_flag, side_b_control_q};
  assign rd_mux     = a_port_sel ? a_rd_val
                    : a_dir_sel  ? side_a_direction_q
                    : a_ctrl_sel ? a_ctrl_rd
                    : b_port_sel ? b_rd_val
                    : b_dir_sel  ? side_b_direction_q
                    : b_ctrl_rd;

  // flags are read-only; only bits 5..0 of a control byte are stored
  always_ff @(posedge mclk)
  begin
    if (srst)
    begin
      side_a_control_q   <= CTRL_RST;
      side_b_control_q   <= CTRL_RST;
      side_a_direction_q <= DIR_RST;
      side_b_direction_q <= DIR_RST;
      side_a_out_latch_q <= LATCH_RST;
      side_b_out_latch_q <= LATCH_RST;
      data_out_q         <= DATA_RST;
      data_oe_q          <= 1'b0;
    end
    else if (ce)
    begin
      if (wr && a_ctrl_sel)
        side_a_control_q <= data_in[5:0];
      if (wr && b_ctrl_sel)
        side_b_control_q <= data_in[5:0];
      if (wr && a_dir_sel)
        side_a_direction_q <= data_in;
      if (wr && b_dir_sel)
        side_b_direction_q <= data_in;
      if (wr && a_port_sel)
        side_a_out_latch_q <= data_in;
      if (wr && b_port_sel)
        side_b_out_latch_q <= data_in;
      if (rd)
        data_out_q <= rd_mux;
      data_oe_q <= rd;
    end
  end

  assign side_a_if.ctrl    = side_a_control_q;
  assign side_a_if.trigger = rd & a_port_sel;
  assign side_a_if.clear   = rd & a_port_sel;
  assign side_b_if.ctrl    = side_b_control_q;
  assign side_b_if.trigger = wr & b_port_sel;
  assign side_b_if.clear   = rd & b_port_sel;

  dph_line_logic u_side_a_line_logic
  (
    .mclk      (mclk),
    .srst      (srst),
    .ce        (ce),
    .strobe_in (side_a_strobe_in),
    .aux_in    (side_a_aux_line_in),
    .sif       (side_a_if)
  );

  dph_line_logic u_side_b_line_logic
  (
    .mclk      (mclk),
    .srst      (srst),
    .ce        (ce),
    .strobe_in (side_b_strobe_in),
    .aux_in    (side_b_aux_line_in),
    .sif       (side_b_if)
  );

  dph_port_io #(.READ_LATCH(1'b0)) u_side_a_port
  (
    .dir      (side_a_direction_q),
    .latch    (side_a_out_latch_q),
    .pins_in  (side_a_pins_in),
    .pins_out (side_a_pins_out),
    .pins_oe  (side_a_pins_oe),
    .rd_val   (a_rd_val)
  );

  dph_port_io #(.READ_LATCH(1'b1)) u_side_b_port
  (
    .dir      (side_b_direction_q),
    .latch    (side_b_out_latch_q),
    .pins_in  (side_b_pins_in),
    .pins_out (side_b_pins_out),
    .pins_oe  (side_b_pins_oe),
    .rd_val   (b_rd_val)
  );

  assign data_out             = data_out_q;
  assign data_oe              = data_oe_q;
  assign side_a_aux_line_out  = side_a_if.aux_out;
  assign side_a_aux_line_oe   = side_a_if.aux_oe;
  assign side_b_aux_line_out  = side_b_if.aux_out;
  assign side_b_aux_line_oe   = side_b_if.aux_oe;
  // open drain: only ever pulls low, so requests can share a wire
  assign side_a_int_req_n_out = 1'b0;
  assign side_a_int_req_n_oe  = side_a_if.irq;
  assign side_b_int_req_n_out = 1'b0;
  assign side_b_int_req_n_oe  = side_b_if.irq;
endmodule

/* File: verification/dph_top_props.sv */
/*
  Port-level checker for dph_top: flags, requests, read-back, aux modes.
  Assumes one mclk domain; control bits are shadowed from bus writes.
*/
`timescale 1ns/10ps
module dph_top_props
  import dph_pkg::*;
(
  input wire logic       mclk,
  input wire logic       srst,
  input wire logic       ce,
  input wire logic       cs0,
  input wire logic       cs1,
  input wire logic       cs2_n,
  input wire logic       read_not_write,
  input wire logic       reg_select_lo,
  input wire logic       reg_select_hi,
  input wire logic [7:0] data_in,
  input wire logic [7:0] data_out,
  input wire logic [7:0] side_a_pins_in,
  input wire logic [7:0] side_b_pins_in,
  input wire logic [7:0] side_b_pins_out,
  input wire logic [7:0] side_b_pins_oe,
  input wire logic       side_a_strobe_in,
  input wire logic       side_a_aux_line_in,
  input wire logic       side_a_aux_line_out,
  input wire logic       side_b_strobe_in,
  input wire logic       side_a_int_req_n_out,
  input wire logic       side_a_int_req_n_oe,
  input wire logic       side_b_int_req_n_out,
  input wire logic       side_b_int_req_n_oe
);
  logic [5:0] ca_q;
  logic [5:0] cb_q;
  logic       sa_q;
  logic       sb_q;
  logic       xa_q;
  logic       vld_q;
  wire        sel = ce & cs0 & cs1 & ~cs2_n;
  wire  [1:0] rsel = {reg_select_hi, reg_select_lo};
  wire        wa = sel & ~read_not_write & (rsel == RS_A_CTRL);
  wire        wb = sel & ~read_not_write & (rsel == RS_B_CTRL);
  wire        rd_a = sel & read_not_write & (rsel == RS_A_DATA) & ca_q[2];
  wire        rd_b = sel & read_not_write & (rsel == RS_B_DATA) & cb_q[2];
  wire        edge_a = vld_q & ce & (ca_q[1] ? ~sa_q & side_a_strobe_in : sa_q & ~side_a_strobe_in);
  wire        edge_b = vld_q & ce & (cb_q[1] ? ~sb_q & side_b_strobe_in : sb_q & ~side_b_strobe_in);
  // any line movement may set a flag again, so clearing is only judged when quiet
  wire        chg_a = vld_q & ce & ((sa_q ^ side_a_strobe_in) | (xa_q ^ side_a_aux_line_in));
  wire  [7:0] bmix = side_b_pins_out & side_b_pins_oe | side_b_pins_in & ~side_b_pins_oe;

  always_ff @(posedge mclk)
  begin
    if (srst)
    begin
      ca_q  <= 6'h00;
      cb_q  <= 6'h00;
      vld_q <= 1'b0;
    end
    else if (ce)
    begin
      vld_q <= 1'b1;
      sa_q  <= side_a_strobe_in;
      sb_q  <= side_b_strobe_in;
      xa_q  <= side_a_aux_line_in;
      if (wa)
        ca_q <= data_in[5:0];
      if (wb)
        cb_q <= data_in[5:0];
    end
  end

  default clocking dck @(posedge mclk);
  endclocking
  default disable iff (srst);

  property p_int_low;
    side_a_int_req_n_out == 1'b0 && side_b_int_req_n_out == 1'b0;
  endproperty
  a_int_low: assert property (p_int_low) else $error("request pin level not low");
  property p_int_gate;
    (ca_q[0] || ca_q[3] || !side_a_int_req_n_oe) && (cb_q[0] || cb_q[3] || !side_b_int_req_n_oe);
  endproperty
  a_int_gate: assert property (p_int_gate) else $error("request with both enables off");
  property p_flag_a;
    edge_a && ca_q[0] && !wa |=> side_a_int_req_n_oe;
  endproperty
  a_flag_a: assert property (p_flag_a) else $error("side a strobe edge lost");
  property p_flag_b;
    edge_b && cb_q[0] && !wb |=> side_b_int_req_n_oe;
  endproperty
  a_flag_b: assert property (p_flag_b) else $error("side b strobe edge lost");
  property p_rd_a;
    rd_a |=> data_out == $past(side_a_pins_in);
  endproperty
  a_rd_a: assert property (p_rd_a) else $error("side a port read wrong");
  property p_rd_b;
    rd_b |=> data_out == $past(bmix);
  endproperty
  a_rd_b: assert property (p_rd_b) else $error("side b port read wrong");
  property p_clr;
    rd_a && !chg_a |=> !side_a_int_req_n_oe;
  endproperty
  a_clr: assert property (p_clr) else $error("side a flags kept after read");
  property p_pulse;
    rd_a && ca_q[5:3] == 3'b101 ##1 ce && !sel |-> !side_a_aux_line_out ##1 side_a_aux_line_out;
  endproperty
  a_pulse: assert property (p_pulse) else $error("side a pulse shape wrong");
  property p_hs;
    ca_q[5:3] == 3'b100 && (edge_a || rd_a) |=> side_a_aux_line_out == $past(edge_a);
  endproperty
  a_hs: assert property (p_hs) else $error("side a handshake level wrong");
  property p_static;
    ce && ca_q[5:4] == 2'b11 |=> side_a_aux_line_out == $past(ca_q[3]);
  endproperty
  a_static: assert property (p_static) else $error("side a static level wrong");

  cover property (edge_a && ca_q[0]);
  cover property (rd_b);
  cover property (rd_a && ca_q[5:3] == 3'b101);
endmodule

bind dph_top dph_top_props u_props (.*);

/* File: verification/dph_periph.sv */
/*
  Peripheral on one side: drives input lines and may load outputs down.
  Assumes enables high while the adapter drives the line.
*/
`timescale 1ns/10ps
module dph_periph
(
  input  wire logic [7:0] pin_out,
  input  wire logic [7:0] pin_oe,
  input  wire logic [7:0] drive,
  input  wire logic [7:0] clamp,
  output logic      [7:0] pin_in,
  input  wire logic       aux_out,
  input  wire logic       aux_oe,
  input  wire logic       aux_drive,
  output logic            aux_in
);
  // a loaded output reads low at the pin
  assign pin_in = pin_oe & pin_out & ~clamp | ~pin_oe & drive;
  assign aux_in = aux_oe ? aux_out : aux_drive;
endmodule

/* File: verification/tb_dual_port_handshake_io.sv */
/*
  Self-checking bench for dph_top with a peripheral model per side.
  Assumes one access per selected mclk cycle, read data one cycle later.
*/
`timescale 1ns/10ps
`define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin failures++; $display("MISMATCH t=%0t got %h exp %h", $time, a, b); end end
module tb_dual_port_handshake_io;
  import dph_pkg::*;
  logic            mclk = 1'b0, srst = 1'b1, cs0 = 1'b0, rnw = 1'b0, ev, qo;
  logic      [1:0] rs = 2'h0, stb = 2'h0, axd = 2'h0, ax1;
  logic      [7:0] din = 8'h00, q, d, l, c;
  logic [1:0][7:0] drv = '0, clp = '0;
  int              failures = 0, n_tests = 0;
  wire       [7:0] dout;
  wire             doe;
  wire [1:0][7:0]  pout, poe, pin;
  wire       [1:0] axo, axoe, axi, ioe;
  // open drain with pull-up: low only while enabled
  wire       [1:0] ion = ~ioe;

  dph_top DUT (
    .mclk(mclk), .srst(srst), .ce(1'b1), .cs0(cs0), .cs1(1'b1), .cs2_n(1'b0),
    .read_not_write(rnw), .reg_select_lo(rs[0]), .reg_select_hi(rs[1]), .data_in(din),
    .data_out(dout), .data_oe(doe),
    .side_a_pins_in(pin[0]), .side_a_pins_out(pout[0]), .side_a_pins_oe(poe[0]),
    .side_b_pins_in(pin[1]), .side_b_pins_out(pout[1]), .side_b_pins_oe(poe[1]),
    .side_a_strobe_in(stb[0]), .side_a_aux_line_in(axi[0]), .side_a_aux_line_out(axo[0]),
    .side_a_aux_line_oe(axoe[0]), .side_b_strobe_in(stb[1]), .side_b_aux_line_in(axi[1]),
    .side_b_aux_line_out(axo[1]), .side_b_aux_line_oe(axoe[1]),
    .side_a_int_req_n_out(), .side_a_int_req_n_oe(ioe[0]),
    .side_b_int_req_n_out(), .side_b_int_req_n_oe(ioe[1])
  );
  for (genvar g = 0; g < 2; g++)
  begin : g_per
    dph_periph u_per (.pin_out(pout[g]), .pin_oe(poe[g]), .drive(drv[g]), .clamp(clp[g]),
      .pin_in(pin[g]), .aux_out(axo[g]), .aux_oe(axoe[g]), .aux_drive(axd[g]), .aux_in(axi[g]));
  end

  initial
  begin
    forever #10 mclk = ~mclk;
  end

  function automatic logic [7:0] mix(input logic [7:0] m, input logic [7:0] a, input logic [7:0] b);
    return m & a | ~m & b;
  endfunction

  // select dropped between accesses so no strobe is driven twice per step
  task automatic acc(input logic r, input logic [1:0] a, input logic [7:0] v);
    cs0 = 1'b1;
    rnw = r;
    rs = a;
    din = v;
    @(negedge mclk);
    q = dout;
    qo = doe;
    ax1 = axo;
    cs0 = 1'b0;
    @(negedge mclk);
  endtask

  task automatic trig(input int s);
    if (s == 0)
      acc(1'b1, 2'h0, 8'h00);
    else
      acc(1'b0, 2'h2, 8'($urandom));
  endtask

  task automatic wrap_up;
    $display("comparisons %0d mismatches %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  initial
  begin
    #100000;
    failures++;
    wrap_up;
  end

  initial
  begin
    void'($urandom(32'hD93001CF));
    repeat (3) @(negedge mclk);
    srst = 1'b0;
    for (int s = 0; s < 2; s++)
    begin
      acc(1'b1, 2'(2*s+1), 8'h00);
      `CHK(q, 8'h00)
      `CHK(qo, 1'b1)
      acc(1'b1, 2'(2*s), 8'h00);
      `CHK(q, DIR_RST)
    end
    $display("test reset done");
    for (int i = 0; i < 6; i++)
    begin
      for (int s = 0; s < 2; s++)
      begin
        d = i == 0 ? 8'hFF : i == 1 ? 8'h00 : 8'($urandom);
        l = 8'($urandom);
        drv[s] = 8'($urandom);
        clp[s] = 8'($urandom);
        acc(1'b0, 2'(2*s+1), 8'h00);
        acc(1'b0, 2'(2*s), d);
        acc(1'b0, 2'(2*s+1), 8'h04);
        acc(1'b0, 2'(2*s), l);
        `CHK(poe[s], d)
        acc(1'b1, 2'(2*s), 8'h00);
        `CHK(q, mix(d, s ? l : l & ~clp[s], drv[s]))
        acc(1'b0, 2'(2*s+1), 8'h00);
        acc(1'b1, 2'(2*s), 8'h00);
        `CHK(q, d)
        clp[s] = 8'h00;
      end
    end
    $display("test ports done");
    for (int s = 0; s < 2; s++)
    begin
      for (int e = 0; e < 2; e++)
      begin
        ev = e[0];
        stb[s] = ~ev;
        axd[s] = ~ev;
        c = {3'b000, ev, 2'b11, ev, 1'b1};
        acc(1'b0, 2'(2*s+1), c);
        acc(1'b1, 2'(2*s), 8'h00);
        stb[s] = ev;
        @(negedge mclk);
        `CHK(ion[s], 1'b0)
        axd[s] = ev;
        @(negedge mclk);
        acc(1'b1, 2'(2*s+1), 8'h00);
        `CHK(q[7:6], 2'b11)
        // strobe enable off: only the aux flag may still pull the request
        acc(1'b0, 2'(2*s+1), c & 8'hFE);
        `CHK(ion[s], 1'b0)
        acc(1'b0, 2'(2*s+1), c & 8'hF6);
        `CHK(ion[s], 1'b1)
        acc(1'b1, 2'(2*s), 8'h00);
        acc(1'b1, 2'(2*s+1), 8'h00);
        `CHK(q[7:6], 2'b00)
        stb[s] = ~ev;
        axd[s] = ~ev;
        @(negedge mclk);
        acc(1'b1, 2'(2*s+1), 8'h00);
        `CHK(q[7:6], 2'b00)
      end
    end
    $display("test flags done");
    for (int s = 0; s < 2; s++)
    begin
      stb[s] = 1'b1;
      acc(1'b0, 2'(2*s+1), 8'h2C);
      trig(s);
      `CHK(ax1[s], 1'b0)
      `CHK(axo[s], 1'b1)
      acc(1'b0, 2'(2*s+1), 8'h24);
      trig(s);
      `CHK(axo[s], 1'b0)
      stb[s] = 1'b0;
      @(negedge mclk);
      `CHK(axo[s], 1'b1)
      for (int b = 0; b < 2; b++)
      begin
        acc(1'b0, 2'(2*s+1), {4'h3, b[0], 3'b100});
        `CHK(axo[s], b[0])
      end
    end
    $display("test aux modes done");
    // mid-run reset with non-zero registers must clear both control bytes and all pin and aux drive enables
    srst = 1'b1;
    @(negedge mclk);
    srst = 1'b0;
    for (int s = 0; s < 2; s++)
    begin
      acc(1'b1, 2'(2*s+1), 8'h00);
      `CHK(q, 8'h00)
      `CHK({poe[s], axoe[s]}, 9'h000)
    end
    $display("test mid reset done");
    wrap_up;
  end
endmodule
